// [logic/usc_pkg.sv]
package usc_pkg;

  // Command codes on the link
  localparam logic [7:0] USC_CMD_EP_FIRST = 8'h40;
  localparam logic [7:0] USC_CMD_EP_LAST = 8'h4B;
  localparam logic [7:0] USC_CMD_DEV_STATUS = 8'hFE;
  localparam logic [7:0] USC_CMD_FRAME = 8'hF5;
  localparam logic [7:0] USC_CMD_PORT_FIRST = 8'hE0;
  localparam logic [7:0] USC_CMD_PORT_LAST = 8'hE2;

  // Counts of endpoints and embedded ports
  localparam int USC_NUM_EP = 12;
  localparam int USC_NUM_PORT = 3;

  // Endpoint control byte fields
  localparam int USC_EP_GUARDED_HALT = 7;
  localparam int USC_EP_RATE_REPORT_SELECT = 6;
  localparam int USC_EP_DISABLE = 5;
  localparam int USC_EP_STALL = 0;

  // Device state and embedded port status fields
  localparam int USC_ST_ATTACH = 0;
  localparam int USC_ST_ATTACH_CHANGED = 1;
  localparam int USC_ST_IDLE = 2;
  localparam int USC_ST_IDLE_CHANGED = 3;
  localparam int USC_ST_RESET = 4;

  // Frame number width
  localparam int USC_FRAME_BITS = 11;

  // Upstream idle time before suspend
  localparam int USC_IDLE_TIME_MS = 3;
  localparam int USC_CLK_KHZ = 250000;
  localparam logic [19:0] USC_IDLE_CYCLES = 20'(USC_IDLE_TIME_MS * USC_CLK_KHZ);

  // Controller register byte offsets
  localparam logic [3:0] USC_REG_CMD = 4'h0;
  localparam logic [3:0] USC_REG_WRITE = 4'h4;
  localparam logic [3:0] USC_REG_READ = 4'h8;
  localparam logic [3:0] USC_REG_STATUS = 4'hC;

  // Controller status fields
  localparam int USC_CS_DONE = 8;
  localparam int USC_CS_IRQ = 9;

  // AXI responses
  localparam logic [1:0] USC_RESP_OKAY = 2'h0;
  localparam logic [1:0] USC_RESP_SLVERR = 2'h2;

  // Command phase of the device, one-hot
  typedef enum logic [4:0] {
    USC_PH_NONE = 5'h01,
    USC_PH_EP = 5'h02,
    USC_PH_DEV = 5'h04,
    USC_PH_FRAME = 5'h08,
    USC_PH_PORT = 5'h10
  } usc_phase_type;

endpackage

// [logic/usc_link_if.sv]
`timescale 1ns/1ps
// Byte link between the command controller and the status unit
interface usc_link_if;
  logic cmd_stb;
  logic wr_stb;
  logic rd_stb;
  logic [7:0] out_byte;
  logic [7:0] in_byte;
  logic rd_ack;
  logic irq;

  modport dev (
    input cmd_stb,
    input wr_stb,
    input rd_stb,
    input out_byte,
    output in_byte,
    output rd_ack,
    output irq
  );

  modport ctl (
    output cmd_stb,
    output wr_stb,
    output rd_stb,
    output out_byte,
    input in_byte,
    input rd_ack,
    input irq
  );
endinterface

// [logic/usc_ctl.sv]
`timescale 1ns/1ps
// Controller end: AXI4-Lite registers turned into link strobes
module usc_ctl (
  input wire logic ref_clk,
  input wire logic rstn,
  usc_link_if.ctl link,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import usc_pkg::*;

  typedef struct packed {
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic cmd_stb;
    logic wr_stb;
    logic rd_stb;
    logic [7:0] obyte;
    logic [7:0] last;
    logic done;
  } usc_ctl_state_type;

  usc_ctl_state_type r;
  usc_ctl_state_type next_r;
  logic wr_go;
  logic rd_go;

  // Address and data are taken together so no half write is ever held
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !r.bvalid;
  assign rd_go = s_axi_arvalid && !r.rvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = !r.rvalid;

  // Register decode and strobe generation
  always_comb begin
    next_r = r;
    next_r.cmd_stb = 1'b0;
    next_r.wr_stb = 1'b0;
    next_r.rd_stb = 1'b0;
    if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
    end
    if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end
    if (wr_go) begin
      next_r.bvalid = 1'b1;
      next_r.bresp = USC_RESP_OKAY;
      case ({s_axi_awaddr[3:2], 2'b00})
        USC_REG_CMD: begin
          next_r.cmd_stb = s_axi_wstrb[0]; // see [RULE20]
          next_r.obyte = s_axi_wdata[7:0];
        end
        USC_REG_WRITE: begin
          next_r.wr_stb = s_axi_wstrb[0];
          next_r.obyte = s_axi_wdata[7:0];
        end
        USC_REG_READ: begin
          next_r.rd_stb = 1'b1;
          next_r.done = 1'b0;
        end
        default: begin
          next_r.bresp = USC_RESP_SLVERR; // Status word is read only
        end
      endcase
    end
    // A returning byte beats the clear of the same cycle
    if (link.rd_ack) begin
      next_r.last = link.in_byte;
      next_r.done = 1'b1;
    end
    if (rd_go) begin
      next_r.rvalid = 1'b1;
      next_r.rresp = USC_RESP_OKAY;
      next_r.rdata = 32'h0000_0000;
      if ({s_axi_araddr[3:2], 2'b00} == USC_REG_STATUS) begin
        next_r.rdata[7:0] = r.last;
        next_r.rdata[USC_CS_DONE] = r.done;
        next_r.rdata[USC_CS_IRQ] = link.irq;
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rresp = r.rresp;
  assign s_axi_rdata = r.rdata;
  assign link.cmd_stb = r.cmd_stb;
  assign link.wr_stb = r.wr_stb;
  assign link.rd_stb = r.rd_stb;
  assign link.out_byte = r.obyte;

endmodule // usc_ctl

// [logic/usc_dev.sv]
`timescale 1ns/1ps
// What this block does
// [RULE1] Endpoint codes take one written control byte
// [RULE2] Guarded halt stalls control pair, setup ignores
// [RULE3] No guarded halt while prior packet replaced
// [RULE4] Bit 6 picks rate report or toggle
// [RULE5] Bit 5 disables endpoint; bus reset re-enables
// [RULE6] Bit 0 stalls; zero unstalls and reinitialises
// [RULE7] Device state read returns one byte
// [RULE8] Device change flags raise the interrupt
// [RULE9] Device state write touches writable bits only
// [RULE10] Bus reset flag, default state, clear on read
// [RULE11] Idle change flag set on change, read clears
// [RULE12] Idle bit after 3 ms without activity
// [RULE13] Writing zero while idle sends remote wake
// [RULE14] Attach change flag, cleared on read
// [RULE15] Attach bit drives pull-up, resets to zero
// [RULE16] Frame command gives low then high byte
// [RULE17] Port status read returns byte, clears flags
// [RULE18] Port idle change or reset raise interrupt
// [RULE19] Port status write touches writable bits only
// [RULE20] Controller sends command before its data phase
module usc_dev #(
  parameter logic [19:0] IDLE_CYCLES = usc_pkg::USC_IDLE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rstn,
  usc_link_if.dev link,
  input wire logic usb_bus_reset,
  input wire logic upstream_activity,
  input wire logic sof_valid,
  input wire logic [usc_pkg::USC_FRAME_BITS-1:0] sof_frame,
  input wire logic control_setup_seen,
  input wire logic prior_packet_replaced,
  input wire logic [usc_pkg::USC_NUM_PORT-1:0] port_idle,
  input wire logic [usc_pkg::USC_NUM_PORT-1:0] port_reset_req,
  output logic [usc_pkg::USC_NUM_EP-1:0] ep_stall,
  output logic [usc_pkg::USC_NUM_EP-1:0] ep_disable,
  output logic [usc_pkg::USC_NUM_EP-1:0] rate_report_select,
  output logic [usc_pkg::USC_NUM_EP-1:0] ep_reinit,
  output logic pullup_en,
  output logic remote_wake,
  output logic enter_default,
  output logic [usc_pkg::USC_NUM_PORT-1:0] port_attach,
  output logic [usc_pkg::USC_NUM_PORT-1:0] port_wake,
  output logic [usc_pkg::USC_NUM_PORT-1:0] port_enable
);
  import usc_pkg::*;

  typedef struct packed {
    usc_phase_type phase;
    logic [3:0] idx;
    logic second;
    logic [USC_NUM_EP-1:0] stall;
    logic [USC_NUM_EP-1:0] dis;
    logic [USC_NUM_EP-1:0] rate;
    logic [USC_NUM_EP-1:0] reinit;
    logic attach;
    logic attach_chg;
    logic idle;
    logic idle_chg;
    logic rst_flag;
    logic wake;
    logic dflt;
    logic [19:0] idle_cnt;
    logic [USC_FRAME_BITS-1:0] frame;
    logic [7:0] rdat;
    logic rack;
    logic [USC_NUM_PORT-1:0] p_attach;
    logic [USC_NUM_PORT-1:0] p_attach_chg;
    logic [USC_NUM_PORT-1:0] p_idle;
    logic [USC_NUM_PORT-1:0] p_idle_chg;
    logic [USC_NUM_PORT-1:0] p_rst;
    logic [USC_NUM_PORT-1:0] p_wake;
    logic [USC_NUM_PORT-1:0] p_enable;
  } usc_dev_state_type;

  usc_dev_state_type r;
  usc_dev_state_type next_r;
  logic clr_dev;
  logic attach_set;
  logic [USC_NUM_PORT-1:0] p_clr;
  logic [USC_NUM_PORT-1:0] p_attach_set;
  logic [7:0] b;
  logic halt_req;
  logic halt_block;

  // Endpoint byte decode, shared by the write path below
  assign b = link.out_byte;
  assign halt_req = b[USC_EP_GUARDED_HALT] && (r.idx == 4'h0);
  assign halt_block = halt_req && (control_setup_seen || prior_packet_replaced); // see [RULE2] see [RULE3]

  // Command interpreter and status bookkeeping
  always_comb begin
    next_r = r;
    clr_dev = 1'b0;
    attach_set = 1'b0;
    p_clr = '0;
    p_attach_set = '0;
    next_r.reinit = '0;
    next_r.wake = 1'b0;
    next_r.dflt = 1'b0;
    next_r.rack = 1'b0;
    next_r.p_wake = '0;
    next_r.p_enable = '0;

    // Idle timer saturates so the idle bit stays set until activity
    if (upstream_activity) begin
      next_r.idle_cnt = 20'h0_0000;
    end else if (r.idle_cnt != IDLE_CYCLES) begin
      next_r.idle_cnt = r.idle_cnt + 20'h0_0001;
    end
    next_r.idle = (next_r.idle_cnt == IDLE_CYCLES); // see [RULE12]

    if (sof_valid) begin
      next_r.frame = sof_frame;
    end

    if (link.cmd_stb) begin
      next_r.second = 1'b0;
      next_r.idx = 4'(link.out_byte[3:0]);
      if (link.out_byte >= USC_CMD_EP_FIRST && link.out_byte <= USC_CMD_EP_LAST) begin
        next_r.phase = USC_PH_EP; // see [RULE1]
      end else if (link.out_byte == USC_CMD_DEV_STATUS) begin
        next_r.phase = USC_PH_DEV;
      end else if (link.out_byte == USC_CMD_FRAME) begin
        next_r.phase = USC_PH_FRAME;
      end else if (link.out_byte >= USC_CMD_PORT_FIRST && link.out_byte <= USC_CMD_PORT_LAST) begin
        next_r.phase = USC_PH_PORT;
        next_r.idx = {2'b00, link.out_byte[1:0]};
      end else begin
        next_r.phase = USC_PH_NONE; // Codes handled elsewhere are ignored
      end
    end else if (link.wr_stb) begin
      case (r.phase)
        USC_PH_EP: begin
          next_r.phase = USC_PH_NONE; // see [RULE1]
          if (!halt_block) begin
            next_r.rate[r.idx] = b[USC_EP_RATE_REPORT_SELECT]; // see [RULE4]
            next_r.dis[r.idx] = b[USC_EP_DISABLE]; // see [RULE5]
            if (halt_req) begin
              next_r.stall[0] = 1'b1; // see [RULE2]
              next_r.stall[1] = 1'b1;
            end else if (b[USC_EP_STALL]) begin
              next_r.stall[r.idx] = 1'b1; // see [RULE6]
            end else begin
              next_r.stall[r.idx] = 1'b0; // see [RULE6]
              next_r.reinit[r.idx] = 1'b1;
            end
          end
        end
        USC_PH_DEV: begin
          next_r.phase = USC_PH_NONE;
          next_r.attach = b[USC_ST_ATTACH]; // see [RULE9] see [RULE15]
          attach_set = (b[USC_ST_ATTACH] != r.attach); // see [RULE14]
          next_r.wake = !b[USC_ST_IDLE] && r.idle; // see [RULE13]
        end
        USC_PH_PORT: begin
          next_r.phase = USC_PH_NONE;
          next_r.p_attach[r.idx[1:0]] = b[USC_ST_ATTACH]; // see [RULE19]
          p_attach_set[r.idx[1:0]] = (b[USC_ST_ATTACH] != r.p_attach[r.idx[1:0]]);
          next_r.p_wake[r.idx[1:0]] = !b[USC_ST_IDLE] && r.p_idle[r.idx[1:0]];
        end
        default: begin
          next_r.phase = r.phase; // Stray write byte has no target
        end
      endcase
    end else if (link.rd_stb) begin
      next_r.rack = 1'b1;
      next_r.rdat = 8'h00;
      case (r.phase)
        USC_PH_DEV: begin
          next_r.phase = USC_PH_NONE;
          next_r.rdat[USC_ST_ATTACH] = r.attach; // see [RULE7]
          next_r.rdat[USC_ST_ATTACH_CHANGED] = r.attach_chg;
          next_r.rdat[USC_ST_IDLE] = r.idle;
          next_r.rdat[USC_ST_IDLE_CHANGED] = r.idle_chg;
          next_r.rdat[USC_ST_RESET] = r.rst_flag;
          clr_dev = 1'b1; // see [RULE10] see [RULE11] see [RULE14]
        end
        USC_PH_FRAME: begin
          if (!r.second) begin
            next_r.rdat = r.frame[7:0]; // see [RULE16]
            next_r.second = 1'b1;
          end else begin
            next_r.rdat = {5'b00000, r.frame[USC_FRAME_BITS-1:8]}; // see [RULE16]
            next_r.phase = USC_PH_NONE;
          end
        end
        USC_PH_PORT: begin
          next_r.phase = USC_PH_NONE;
          next_r.rdat[USC_ST_ATTACH] = r.p_attach[r.idx[1:0]]; // see [RULE17]
          next_r.rdat[USC_ST_ATTACH_CHANGED] = r.p_attach_chg[r.idx[1:0]];
          next_r.rdat[USC_ST_IDLE] = r.p_idle[r.idx[1:0]];
          next_r.rdat[USC_ST_IDLE_CHANGED] = r.p_idle_chg[r.idx[1:0]];
          next_r.rdat[USC_ST_RESET] = r.p_rst[r.idx[1:0]];
          p_clr[r.idx[1:0]] = 1'b1;
          next_r.p_enable[r.idx[1:0]] = r.p_rst[r.idx[1:0]]; // End of port reset
        end
        default: begin
          next_r.phase = r.phase; // Unread phase answers zero
        end
      endcase
    end

    // Bus reset comes last so it overrides a disable in the same cycle
    if (usb_bus_reset) begin
      next_r.dis = '0; // see [RULE5]
      next_r.dflt = 1'b1; // see [RULE10]
    end

    // Sticky flags: a new event wins over a read-clear
    next_r.rst_flag = (r.rst_flag && !clr_dev) || usb_bus_reset; // see [RULE10]
    next_r.idle_chg = (r.idle_chg && !clr_dev) || (next_r.idle != r.idle); // see [RULE11]
    next_r.attach_chg = (r.attach_chg && !clr_dev) || attach_set; // see [RULE14]
    for (int i = 0; i < USC_NUM_PORT; i++) begin
      next_r.p_idle[i] = port_idle[i];
      next_r.p_idle_chg[i] = (r.p_idle_chg[i] && !p_clr[i]) || (port_idle[i] != r.p_idle[i]); // see [RULE17]
      next_r.p_attach_chg[i] = (r.p_attach_chg[i] && !p_clr[i]) || p_attach_set[i];
      next_r.p_rst[i] = (r.p_rst[i] && !p_clr[i]) || port_reset_req[i];
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
      r.phase <= USC_PH_NONE;
    end else begin
      r <= next_r;
    end
  end

  // Interrupt is a level while any change flag other than a port attach change stands
  assign link.irq = r.rst_flag || r.idle_chg || r.attach_chg || (|r.p_idle_chg) || (|r.p_rst); // see [RULE8] see [RULE18]
  assign link.in_byte = r.rdat;
  assign link.rd_ack = r.rack;
  assign ep_stall = r.stall;
  assign ep_disable = r.dis;
  assign rate_report_select = r.rate;
  assign ep_reinit = r.reinit;
  assign pullup_en = r.attach;
  assign remote_wake = r.wake;
  assign enter_default = r.dflt;
  assign port_attach = r.p_attach;
  assign port_wake = r.p_wake;
  assign port_enable = r.p_enable;

endmodule // usc_dev

// [tb/usc_link_props.sv]
`timescale 1ns/1ps
// Link checker; helper logic tracks the open command
module usc_link_props
  import usc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic cmd_stb,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] out_byte,
  input wire logic [7:0] in_byte,
  input wire logic rd_ack,
  input wire logic irq
);
  logic [7:0] cmd_q;
  logic [1:0] n_rd;
  logic is_st;
  logic is_ep;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Command classes by code range
  assign is_st = cmd_q == USC_CMD_DEV_STATUS || cmd_q inside {[USC_CMD_PORT_FIRST:USC_CMD_PORT_LAST]};
  assign is_ep = cmd_q inside {[USC_CMD_EP_FIRST:USC_CMD_EP_LAST]};
  // Reads per command; saturates so a long tail stays harmless
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cmd_q <= 8'h00;
      n_rd <= 2'h0;
    end else if (cmd_stb) begin
      cmd_q <= out_byte;
      n_rd <= 2'h0;
    end else if (rd_ack && n_rd != 2'h3) begin
      n_rd <= n_rd + 2'h1;
    end
  end
  property p_ack_next; rd_stb |=> rd_ack; endproperty
  a_ack_next: assert property (p_ack_next) else $error("read not answered");
  property p_ack_cause; rd_ack |-> $past(rd_stb); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("answer without read");
  property p_cmd_one; cmd_stb |=> !cmd_stb; endproperty
  a_cmd_one: assert property (p_cmd_one) else $error("command strobe too long");
  property p_wr_one; wr_stb |=> !wr_stb; endproperty
  a_wr_one: assert property (p_wr_one) else $error("write strobe too long");
  property p_hold; !rd_ack |-> $stable(in_byte); endproperty
  a_hold: assert property (p_hold) else $error("read byte moved");
  property p_ep_rd; rd_ack && is_ep |-> in_byte == 8'h00; endproperty
  a_ep_rd: assert property (p_ep_rd) else $error("endpoint read not zero");
  property p_rsvd; rd_ack && is_st |-> in_byte[7:5] == 3'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved status bits set");
  property p_frm_hi; rd_ack && cmd_q == USC_CMD_FRAME && n_rd == 2'h1 |-> in_byte[7:3] == 5'h00; endproperty
  a_frm_hi: assert property (p_frm_hi) else $error("frame high byte not padded");
  property p_irq_dev;
    rd_ack && cmd_q == USC_CMD_DEV_STATUS && (in_byte[4] || in_byte[3] || in_byte[1]) |-> $past(irq);
  endproperty
  a_irq_dev: assert property (p_irq_dev) else $error("device flag without irq");
  property p_irq_port;
    rd_ack && is_st && cmd_q != USC_CMD_DEV_STATUS && (in_byte[4] || in_byte[3]) |-> $past(irq);
  endproperty
  a_irq_port: assert property (p_irq_port) else $error("port flag without irq");
  c_frame: cover property (rd_ack && cmd_q == USC_CMD_FRAME && n_rd == 2'h1);
  c_bus_rst: cover property (rd_ack && cmd_q == USC_CMD_DEV_STATUS && in_byte[4]);
  c_ep_wr: cover property (wr_stb && is_ep);
endmodule // usc_link_props

// [tb/usc_tb.sv]
`timescale 1ns/1ps
// Both ends joined by the link; software side over AXI, USB side by hand
module usc_tb;
  import usc_pkg::*;
  localparam logic [19:0] IDLE_N = 20'h0_0014;
  logic ref_clk, rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic usb_bus_reset, upstream_activity, sof_valid, control_setup_seen, prior_packet_replaced;
  logic pullup_en, remote_wake, enter_default, dflt_seen;
  logic [USC_FRAME_BITS-1:0] sof_frame;
  logic [2:0] port_idle, port_reset_req, port_attach, port_wake, port_enable, pen_seen, pwk_seen;
  logic [11:0] ep_stall, ep_disable, rate_report_select, ep_reinit, rein_seen;
  logic [7:0] b;
  int n_errors, n_compared, wake_n;
  usc_link_if usc_link_if_inst ();
  usc_ctl usc_ctl_inst (.ref_clk, .rstn, .link(usc_link_if_inst), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  usc_dev #(.IDLE_CYCLES(IDLE_N)) usc_dev_inst (.ref_clk, .rstn, .link(usc_link_if_inst), .usb_bus_reset,
    .upstream_activity, .sof_valid, .sof_frame, .control_setup_seen, .prior_packet_replaced, .port_idle,
    .port_reset_req, .ep_stall, .ep_disable, .rate_report_select, .ep_reinit, .pullup_en, .remote_wake,
    .enter_default, .port_attach, .port_wake, .port_enable);
  usc_link_props usc_link_props_inst (.ref_clk, .rstn, .cmd_stb(usc_link_if_inst.cmd_stb),
    .wr_stb(usc_link_if_inst.wr_stb), .rd_stb(usc_link_if_inst.rd_stb), .out_byte(usc_link_if_inst.out_byte),
    .in_byte(usc_link_if_inst.in_byte), .rd_ack(usc_link_if_inst.rd_ack), .irq(usc_link_if_inst.irq));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // Pulses last one cycle, so they are gathered as sticky flags; remote wake pulses are counted
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rein_seen <= '0;
      dflt_seen <= 1'b0;
      pen_seen <= '0;
      pwk_seen <= '0;
      wake_n <= 0;
    end else begin
      rein_seen <= rein_seen | ep_reinit;
      dflt_seen <= dflt_seen | enter_default;
      pen_seen <= pen_seen | port_enable;
      pwk_seen <= pwk_seen | port_wake;
      wake_n <= wake_n + int'(remote_wake);
    end
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task axi_wr(input logic [3:0] a, input logic [31:0] x);
    s_axi_awaddr <= a;
    s_axi_wdata <= x;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(posedge ref_clk); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b1;
    do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task axi_rd(input logic [3:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Slack after each write lets link effects and sticky flags land
  task put(input logic [3:0] a, input logic [7:0] x);
    axi_wr(a, {24'h00_0000, x});
    repeat (3) @(posedge ref_clk);
  endtask
  task rb;
    put(USC_REG_READ, 8'h00);
    do axi_rd(USC_REG_STATUS); while (d[USC_CS_DONE] !== 1'b1);
    b = d[7:0];
  endtask
  task ask(input logic [7:0] c);
    put(USC_REG_CMD, c);
    rb();
  endtask
  task t_reset;
    put(USC_REG_STATUS, 8'h00);
    chk(r, USC_RESP_SLVERR);
    ask(USC_CMD_DEV_STATUS);
    chk(b, 8'h00);
    chk(pullup_en, 1'b0);
    $display("done t_reset");
  endtask
  task t_ep;
    ask(8'h45);
    chk(b, 8'h00);
    for (int i = 0; i < USC_NUM_EP; i++) begin
      put(USC_REG_CMD, USC_CMD_EP_FIRST + 8'(i));
      put(USC_REG_WRITE, 8'h21);
    end
    chk(ep_stall, 12'hFFF);
    chk(ep_disable, 12'hFFF);
    chk(rein_seen, 12'h000);
    usb_bus_reset <= 1'b1;
    @(posedge ref_clk);
    usb_bus_reset <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk(ep_disable, 12'h000);
    chk(dflt_seen, 1'b1);
    axi_rd(USC_REG_STATUS);
    chk(d[USC_CS_IRQ], 1'b1);
    chk(r, USC_RESP_OKAY);
    ask(USC_CMD_DEV_STATUS);
    chk(b, 8'h10);
    ask(USC_CMD_DEV_STATUS);
    chk(b, 8'h00);
    for (int i = 0; i < USC_NUM_EP; i++) begin
      put(USC_REG_CMD, USC_CMD_EP_FIRST + 8'(i));
      put(USC_REG_WRITE, 8'h40);
    end
    chk(ep_stall, 12'h000);
    chk(rein_seen, 12'hFFF);
    chk(rate_report_select, 12'hFFF);
    $display("done t_ep");
  endtask
  task t_guard;
    control_setup_seen <= 1'b1;
    put(USC_REG_CMD, USC_CMD_EP_FIRST);
    put(USC_REG_WRITE, 8'hA1);
    chk(ep_stall[1:0], 2'b00);
    chk(ep_disable[0], 1'b0);
    control_setup_seen <= 1'b0;
    prior_packet_replaced <= 1'b1;
    put(USC_REG_CMD, USC_CMD_EP_FIRST);
    put(USC_REG_WRITE, 8'hA1);
    chk(ep_stall[1:0], 2'b00);
    prior_packet_replaced <= 1'b0;
    put(USC_REG_CMD, USC_CMD_EP_FIRST);
    put(USC_REG_WRITE, 8'hA1);
    chk(ep_stall[1:0], 2'b11);
    chk(rate_report_select[0], 1'b0);
    chk(ep_disable[0], 1'b1);
    // Zero byte re-enables and unstalls only the addressed endpoint
    put(USC_REG_CMD, USC_CMD_EP_FIRST);
    put(USC_REG_WRITE, 8'h00);
    chk(ep_disable[0], 1'b0);
    chk(ep_stall[1:0], 2'b10);
    $display("done t_guard");
  endtask
  // Writes and clear-on-read of the device state, then the idle timer
  task t_dev;
    put(USC_REG_CMD, USC_CMD_DEV_STATUS);
    put(USC_REG_WRITE, 8'hF9);
    chk(r, USC_RESP_OKAY);
    chk(pullup_en, 1'b1);
    ask(USC_CMD_DEV_STATUS);
    chk(b, 8'h03);
    ask(USC_CMD_DEV_STATUS);
    chk(b, 8'h01);
    put(USC_REG_CMD, USC_CMD_DEV_STATUS);
    put(USC_REG_WRITE, 8'h00);
    chk(pullup_en, 1'b0);
    chk(wake_n, 0);
    upstream_activity <= 1'b0;
    repeat (int'(IDLE_N) + 4) @(posedge ref_clk);
    ask(USC_CMD_DEV_STATUS);
    chk(b, 8'h0E);
    put(USC_REG_CMD, USC_CMD_DEV_STATUS);
    put(USC_REG_WRITE, 8'h04);
    chk(wake_n, 0);
    put(USC_REG_CMD, USC_CMD_DEV_STATUS);
    put(USC_REG_WRITE, 8'h00);
    chk(wake_n, 1);
    upstream_activity <= 1'b1;
    ask(USC_CMD_DEV_STATUS);
    chk(b, 8'h08);
    $display("done t_dev");
  endtask
  task t_frame;
    sof_frame <= 11'h5A3;
    sof_valid <= 1'b1;
    @(posedge ref_clk);
    sof_valid <= 1'b0;
    sof_frame <= 11'h7FF;
    ask(USC_CMD_FRAME);
    chk(b, 8'hA3);
    rb();
    chk(b, 8'h05);
    $display("done t_frame");
  endtask
  task t_port;
    port_idle <= 3'b010;
    port_reset_req <= 3'b100;
    @(posedge ref_clk);
    port_reset_req <= 3'b000;
    axi_rd(USC_REG_STATUS);
    chk(d[USC_CS_IRQ], 1'b1);
    ask(8'hE1);
    chk(b, 8'h0C);
    ask(8'hE1);
    chk(b, 8'h04);
    ask(USC_CMD_PORT_LAST);
    chk(b, 8'h10);
    chk(pen_seen, 3'b100);
    put(USC_REG_CMD, USC_CMD_PORT_FIRST);
    put(USC_REG_WRITE, 8'hF1);
    chk(port_attach, 3'b001);
    put(USC_REG_CMD, 8'hE1);
    put(USC_REG_WRITE, 8'h00);
    chk(pwk_seen, 3'b010);
    $display("done t_port");
  endtask
  task results;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    {rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, usb_bus_reset, sof_valid, sof_frame} = '0;
    {control_setup_seen, prior_packet_replaced, port_idle, port_reset_req} = '0;
    {n_errors, n_compared} = '0;
    s_axi_wstrb = 4'hF;
    upstream_activity = 1'b1;
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_ep();
    t_guard();
    t_dev();
    t_frame();
    t_port();
    results();
  end
  // Cuts a hang short well beyond the expected run
  initial begin
    repeat (50000) @(posedge ref_clk);
    n_errors++;
    results();
  end
endmodule // usc_tb
